// ### core/sfq_cfg.svh
// Constants of the quad serial flash command block
`ifndef SFQ_CFG_SVH
`define SFQ_CFG_SVH
// ======================================
// Command codes
`define SFQ_OP_UNLOCK 8'h06
`define SFQ_OP_LOCK 8'h04
`define SFQ_OP_STATUS 8'h05
`define SFQ_OP_QREAD 8'hEB
`define SFQ_OP_QWORD 8'hE7
`define SFQ_OP_SET_WRAP 8'h77
`define SFQ_OP_PAGE_WRITE 8'h02
// ======================================
// Phase lengths in serial clocks
`define SFQ_CMD_CLKS 6'h08
`define SFQ_QADDR_CLKS 6'h06
`define SFQ_MODE_CLKS 6'h02
`define SFQ_DUMMY_BYTE 6'h04
`define SFQ_DUMMY_WORD 6'h02
`define SFQ_SADDR_CLKS 6'h18
`define SFQ_WRAP_CLKS 6'h20
// ======================================
// Field values and defaults
`define SFQ_CONT_KEY 2'h2
`define SFQ_WRAP_RST 3'h1
`define SFQ_PAGE_BYTES 9'h100
`define SFQ_PROG_CYCLES 1000
`endif

// ### core/sfq_core.sv
// Command logic of the quad serial flash: quad reads, wrap, page program
`timescale 1ns/1ns
`default_nettype none
`include "sfq_cfg.svh"
module sfq_core
  import sfq_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `SFQ_PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] lanes_i,
  output logic [3:0] lanes_o,
  output logic [3:0] lanes_oe_o,
  input wire logic quad_lane_enable_i,
  input wire logic [5:0] status_upper_i,
  input wire logic page_protected_i,
  output logic [15:0] prog_page_o,
  output logic [23:0] mem_rd_addr_o,
  input wire logic [7:0] mem_rd_data_i,
  output logic mem_wr_en_o,
  output logic [23:0] mem_wr_addr_o,
  output logic [7:0] mem_wr_data_o,
  output logic write_in_progress_o,
  output logic write_enable_latch_o,
  output logic cont_read_o,
  output logic [2:0] wrap_setting_o
);
  // ======================================
  // Pin synchronisation and edge detection
  sfq_pins_s pins;
  logic sclk_q;
  logic csn_q;
  sfq_sync #(.W(6)) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i({cs_n_i, sclk_i, lanes_i}),
    .q_o(pins)
  );
  wire rise = pins.sclk & ~sclk_q & ~pins.cs_n;
  wire fall = ~pins.sclk & sclk_q & ~pins.cs_n;
  wire cs_rise = pins.cs_n & ~csn_q;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
    end else begin
      sclk_q <= pins.sclk;
      csn_q <= pins.cs_n;
    end
  end

  // ======================================
  // Wrap-aware address step inside an aligned section
  function automatic logic [23:0] step_addr(input logic [23:0] a,
                                            input logic [2:0] ws);
    logic [5:0] m;
    logic [5:0] lo;
    m = 6'h3F >> (2'h3 - ws[2:1]);
    lo = a[5:0] + 6'h01;
    if (ws[0]) begin
      step_addr = a + 24'h000001;
    end else begin
      step_addr = {a[23:6], (a[5:0] & ~m) | (lo & m)};
    end
  endfunction : step_addr

  // ======================================
  // State and shift registers
  sfq_state_e st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] sh_q;
  logic word_q;
  logic cont_q;
  logic wel_q;
  logic wip_q;
  logic [2:0] wrap_setting_q;
  logic [23:0] addr_q;
  logic nib_q;
  logic [3:0] hold_q;
  logic [3:0] lanes_q;
  logic [23:0] pp_addr_q;
  logic pp_data_q;
  logic pp_any_q;
  logic [7:0] page_buf [0:255];
  logic [255:0] valid_q;
  logic [31:0] prog_cnt_q;
  logic [8:0] scan_q;
  logic wr_en_q;
  logic [23:0] wr_addr_q;
  logic [7:0] wr_data_q;

  // Quad phases take a nibble per clock, the rest one bit
  wire quad_ph = (st_q == SFQ_ADDR) | (st_q == SFQ_MODE) | (st_q == SFQ_DUMMY);
  wire [31:0] sh_in = quad_ph ? {sh_q[27:0], pins.lanes} : {sh_q[30:0], pins.lanes[0]};
  wire [5:0] cnt_n = cnt_q + 6'h01;
  wire [7:0] op = sh_in[7:0];
  wire cmd_done = rise & (st_q == SFQ_CMD) & (cnt_n == `SFQ_CMD_CLKS);
  wire addr_done = rise & (st_q == SFQ_ADDR) & (cnt_n == `SFQ_QADDR_CLKS);
  wire mode_done = rise & (st_q == SFQ_MODE) & (cnt_n == `SFQ_MODE_CLKS);
  wire [5:0] dummy_len = word_q ? `SFQ_DUMMY_WORD : `SFQ_DUMMY_BYTE;
  wire pp_adr_done = rise & (st_q == SFQ_PROG) & ~pp_data_q & (cnt_n == `SFQ_SADDR_CLKS);
  wire pp_byte = rise & (st_q == SFQ_PROG) & pp_data_q & (cnt_n[2:0] == 3'h0);
  wire wrap_done = rise & (st_q == SFQ_WRAP) & (cnt_n == `SFQ_WRAP_CLKS);
  wire is_qread = (op == `SFQ_OP_QREAD) | (op == `SFQ_OP_QWORD);
  wire quad_ok = quad_lane_enable_i & ~wip_q;
  wire pp_ok = wel_q & ~wip_q;
  // A program runs only when deselect lands on a byte boundary
  wire pp_aligned = (st_q == SFQ_PROG) & pp_data_q & pp_any_q & (cnt_q[2:0] == 3'h0);
  wire prog_go = cs_rise & pp_aligned & ~page_protected_i;
  wire [7:0] status_low = {status_upper_i, wel_q, wip_q};

  // ======================================
  // Next state; continuous mode resumes at the address
  always_comb begin
    st_d = st_q;
    if (pins.cs_n) begin
      st_d = cont_q ? SFQ_ADDR : SFQ_CMD;
    end else if (rise) begin
      case (st_q)
        SFQ_CMD: begin
          if (cnt_n == `SFQ_CMD_CLKS) begin
            if (op == `SFQ_OP_STATUS) begin
              st_d = SFQ_STAT;
            end else if (is_qread) begin
              st_d = quad_ok ? SFQ_ADDR : SFQ_IGNORE;
            end else if (op == `SFQ_OP_SET_WRAP) begin
              st_d = wip_q ? SFQ_IGNORE : SFQ_WRAP;
            end else if (op == `SFQ_OP_PAGE_WRITE) begin
              st_d = pp_ok ? SFQ_PROG : SFQ_IGNORE;
            end else begin
              st_d = SFQ_IGNORE;
            end
          end
        end
        SFQ_ADDR: if (addr_done) st_d = SFQ_MODE;
        SFQ_MODE: if (mode_done) st_d = SFQ_DUMMY;
        SFQ_DUMMY: if (cnt_n == dummy_len) st_d = SFQ_DATA;
        SFQ_WRAP: if (wrap_done) st_d = SFQ_IGNORE;
        default: st_d = st_q;
      endcase
    end
  end

  // Counter restarts at every state change
  always_comb begin
    cnt_d = cnt_q;
    if (pins.cs_n) begin
      cnt_d = 6'h00;
    end else if (rise) begin
      cnt_d = (st_d != st_q) ? 6'h00 : cnt_n;
    end
  end

  // ======================================
  // Command framing registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q <= SFQ_CMD;
      cnt_q <= 6'h00;
      sh_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      if (rise) sh_q <= sh_in;
    end
  end

  // ======================================
  // Read mode: continuous key, word flag and wrap setting
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cont_q <= 1'b0;
      word_q <= 1'b0;
      wrap_setting_q <= `SFQ_WRAP_RST;
    end else begin
      if (cmd_done && is_qread) word_q <= (op == `SFQ_OP_QWORD);
      if (mode_done) cont_q <= (sh_in[5:4] == `SFQ_CONT_KEY);
      if (wrap_done) wrap_setting_q <= sh_in[6:4];
    end
  end

  // ======================================
  // Read address and nibble output on falling clock
  // Memory has most of a serial clock to answer before each byte.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      addr_q <= 24'h000000;
      nib_q <= 1'b0;
      hold_q <= 4'h0;
      lanes_q <= 4'h0;
    end else begin
      if (addr_done) begin
        addr_q <= sh_in[23:0];
      end
      if (pins.cs_n) begin
        nib_q <= 1'b0;
      end else if (fall && st_q == SFQ_DATA) begin
        nib_q <= ~nib_q;
        if (!nib_q) begin
          lanes_q <= mem_rd_data_i[7:4];
          hold_q <= mem_rd_data_i[3:0];
        end else begin
          lanes_q <= hold_q;
          addr_q <= step_addr(addr_q, wrap_setting_q);
        end
      end else if (fall && st_q == SFQ_STAT) begin
        lanes_q <= {2'h0, status_low[3'h7 - cnt_q[2:0]], 1'b0};
      end
    end
  end

  // Read data drives all lanes, status only lane 1
  assign lanes_oe_o = pins.cs_n ? 4'h0 :
                      (st_q == SFQ_DATA) ? 4'hF :
                      (st_q == SFQ_STAT) ? 4'h2 : 4'h0;
  assign lanes_o = lanes_q;
  assign mem_rd_addr_o = addr_q;

  // ======================================
  // Page program latch; low address byte wraps in the page
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pp_addr_q <= 24'h000000;
      pp_data_q <= 1'b0;
      pp_any_q <= 1'b0;
      valid_q <= '0;
    end else if (cmd_done && op == `SFQ_OP_PAGE_WRITE && pp_ok) begin
      pp_data_q <= 1'b0;
      pp_any_q <= 1'b0;
      valid_q <= '0;
    end else if (pp_adr_done) begin
      pp_addr_q <= sh_in[23:0];
      pp_data_q <= 1'b1;
    end else if (pp_byte) begin
      valid_q[pp_addr_q[7:0]] <= 1'b1;
      pp_addr_q[7:0] <= pp_addr_q[7:0] + 8'h01;
      pp_any_q <= 1'b1;
    end
  end

  // Later bytes overwrite earlier ones at the same page offset
  always_ff @(posedge clk_i) begin
    if (pp_byte) page_buf[pp_addr_q[7:0]] <= sh_in[7:0];
  end

  // ======================================
  // Write enable latch and self-timed program cycle
  // A new program is refused while busy, so the page buffer is stable.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      prog_cnt_q <= 32'h00000000;
      scan_q <= 9'h000;
    end else if (prog_go) begin
      wip_q <= 1'b1;
      wel_q <= 1'b0;
      prog_cnt_q <= 32'(PROG_CYCLES - 1);
      scan_q <= 9'h000;
    end else if (wip_q) begin
      if (prog_cnt_q == 32'h00000000) wip_q <= 1'b0;
      prog_cnt_q <= prog_cnt_q - 32'h00000001;
      if (scan_q != `SFQ_PAGE_BYTES) scan_q <= scan_q + 9'h001;
    end else if (cmd_done && op == `SFQ_OP_UNLOCK) begin
      wel_q <= 1'b1;
    end else if (cmd_done && op == `SFQ_OP_LOCK) begin
      wel_q <= 1'b0;
    end
  end

  // Only latched bytes reach the array; the rest keep their data
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wr_en_q <= 1'b0;
      wr_addr_q <= 24'h000000;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q <= wip_q & ~scan_q[8] & valid_q[scan_q[7:0]];
      wr_addr_q <= {pp_addr_q[23:8], scan_q[7:0]};
      wr_data_q <= page_buf[scan_q[7:0]];
    end
  end

  assign mem_wr_en_o = wr_en_q;
  assign mem_wr_addr_o = wr_addr_q;
  assign mem_wr_data_o = wr_data_q;
  assign prog_page_o = pp_addr_q[23:8];
  assign write_in_progress_o = wip_q;
  assign write_enable_latch_o = wel_q;
  assign cont_read_o = cont_q;
  assign wrap_setting_o = wrap_setting_q;

  // ======================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_quad_gate: assert property (
    cmd_done && is_qread && !quad_lane_enable_i |=> st_q == SFQ_IGNORE)
    else $error("quad read accepted without lane enable");
  chk_cont_enter: assert property (
    mode_done && sh_in[5:4] == `SFQ_CONT_KEY |=> cont_q)
    else $error("continuous mode not entered");
  chk_cont_leave: assert property (
    mode_done && sh_in[5:4] != `SFQ_CONT_KEY |=> !cont_q)
    else $error("continuous mode not left");
  chk_cont_resume: assert property (
    cont_q && pins.cs_n |=> st_q == SFQ_ADDR)
    else $error("continuous frame does not start at address");
  chk_word_dummy: assert property (
    rise && st_q == SFQ_DUMMY && word_q && cnt_n == `SFQ_DUMMY_WORD
    |=> st_q == SFQ_DATA)
    else $error("word read dummy count wrong");
  chk_wrap_section: assert property (
    fall && st_q == SFQ_DATA && nib_q && !wrap_setting_q[0]
    |=> addr_q[23:6] == $past(addr_q[23:6]))
    else $error("wrapped read left its section");
  chk_pp_unlock: assert property (
    cmd_done && op == `SFQ_OP_PAGE_WRITE && !wel_q |=> st_q != SFQ_PROG)
    else $error("program accepted without write enable");
  chk_page_wrap: assert property (
    pp_byte |=> pp_addr_q[23:8] == $past(pp_addr_q[23:8]))
    else $error("program address left the page");
  chk_misaligned: assert property (
    cs_rise && st_q == SFQ_PROG && cnt_q[2:0] != 3'h0 && !wip_q |=> !wip_q)
    else $error("misaligned program was started");
  chk_protect_drop: assert property (
    cs_rise && !wip_q && page_protected_i |=> !wip_q)
    else $error("protected page programmed");
  chk_prog_flags: assert property (
    prog_go |=> wip_q && !wel_q ##1 wip_q)
    else $error("program cycle flags wrong");

  cov_cont_read: cover property (mode_done && sh_in[5:4] == `SFQ_CONT_KEY);
  cov_program: cover property (prog_go);
  cov_wrap_read: cover property (fall && st_q == SFQ_DATA && !wrap_setting_q[0]);
endmodule : sfq_core
`default_nettype wire

// ### core/sfq_pkg.sv
// Types shared by the quad serial flash command block
package sfq_pkg;
  // ======================================
  // Command states, Gray coded along the read path
  typedef enum logic [3:0] {
    SFQ_CMD = 4'h0,
    SFQ_ADDR = 4'h1,
    SFQ_MODE = 4'h3,
    SFQ_DUMMY = 4'h2,
    SFQ_DATA = 4'h6,
    SFQ_STAT = 4'h7,
    SFQ_PROG = 4'h5,
    SFQ_WRAP = 4'h4,
    SFQ_IGNORE = 4'hC
  } sfq_state_e;
  // Pin group crossing into the clock domain
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] lanes;
  } sfq_pins_s;
endpackage : sfq_pkg

// ### core/sfq_sync.sv
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ns
`default_nettype none
module sfq_sync #(
  parameter int W = 6
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  // ======================================
  // First stage feeds only the second; idle pins reset high
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_q <= {W{1'b1}};
      s2_q <= {W{1'b1}};
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule : sfq_sync
`default_nettype wire

// ### testbench/sfq_host.sv
// Host serial controller model: drives select, serial clock and the four lanes
`timescale 1ns/1ns
`default_nettype none
module sfq_host (
  input wire logic clk_i,
  input wire logic [3:0] dev_i,
  input wire logic [3:0] dev_oe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] lanes_o
);
  logic [3:0] drv = 4'h0;
  logic [3:0] drv_oe = 4'h0;
  logic [3:0] idle = 4'h5;
  logic [3:0] smp;
  // Wire level; a lane nobody drives toggles so a stale level never passes for data
  assign lanes_o = (dev_oe_i & dev_i) | (~dev_oe_i & ((drv_oe & drv) | (~drv_oe & idle)));
  // Serial clock rests low outside frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  // One clock of 125 ns: lanes change after the fall and hold through the rise
  task automatic cyc(input logic [3:0] v, input logic [3:0] oe);
    drv = v;
    drv_oe = oe;
    idle = ~idle;
    #62 sclk_o = 1'b1;
    smp = lanes_o;
    #63 sclk_o = 1'b0;
  endtask : cyc
  // Offset from the clock edges so the pins never move on a sampling edge
  task automatic open_frame();
    @(negedge clk_i);
    #2 cs_n_o = 1'b0;
    // 64 ns keeps every later lane and clock edge off the rising clk edge
    #64;
  endtask : open_frame
  task automatic close_frame();
    #63 cs_n_o = 1'b1;
    drv_oe = 4'h0;
    #250;
  endtask : close_frame
  task automatic send8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) cyc({3'h0, b[i]}, 4'h1);
  endtask : send8
  task automatic recv_q(output logic [7:0] r);
    cyc(4'h0, 4'h0);
    r[7:4] = smp;
    cyc(4'h0, 4'h0);
    r[3:0] = smp;
  endtask : recv_q
  task automatic recv_s(output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      cyc(4'h0, 4'h0);
      r[i] = smp[1];
    end
  endtask : recv_s
endmodule : sfq_host
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the quad serial flash command block
`timescale 1ns/1ns
`default_nettype none
`include "sfq_cfg.svh"
module testbench;
  typedef struct {
    logic [7:0] op;
    logic skip;
    logic [7:0] wrap;
    logic [23:0] addr;
    logic [7:0] mode;
    int n;
  } sfq_row_s;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic qe = 1'b1;
  logic cs_n, sclk, wr_en, write_in_progress, write_enable_latch, cont;
  logic [3:0] lanes_in, lanes_out, lanes_oe;
  logic [15:0] page;
  logic [23:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data, got;
  logic [7:0] cur_wrap = 8'h10;
  logic [2:0] wrap_set;
  logic [7:0] wr_mem [logic [23:0]];
  int failures = 0;
  int comparisons = 0;
  int wr_cnt = 0;
  // ======================================
  // Rows: opcode, skip opcode, wrap byte, start address, mode byte, bytes read
  sfq_row_s rows [8] = '{
    '{`SFQ_OP_QREAD, 1'b0, 8'h10, 24'h0012FE, 8'h00, 4},
    '{`SFQ_OP_QWORD, 1'b0, 8'h00, 24'h000106, 8'h20, 6},
    '{`SFQ_OP_QWORD, 1'b1, 8'h00, 24'h00020C, 8'hF0, 8},
    '{`SFQ_OP_QREAD, 1'b0, 8'h20, 24'h00033A, 8'h20, 8},
    '{`SFQ_OP_QREAD, 1'b1, 8'h20, 24'h000456, 8'h00, 4},
    '{`SFQ_OP_QREAD, 1'b0, 8'h40, 24'h00051E, 8'h00, 4},
    '{`SFQ_OP_QWORD, 1'b0, 8'h60, 24'h00067C, 8'h00, 6},
    '{`SFQ_OP_QREAD, 1'b0, 8'h10, 24'h00071F, 8'h00, 3}};
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  sfq_core #(.PROG_CYCLES(300)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sclk_i(sclk), .lanes_i(lanes_in),
    .lanes_o(lanes_out), .lanes_oe_o(lanes_oe), .quad_lane_enable_i(qe),
    .status_upper_i(6'h15), .page_protected_i(page === 16'h0030), .prog_page_o(page),
    .mem_rd_addr_o(rd_addr), .mem_rd_data_i(rd_data), .mem_wr_en_o(wr_en),
    .mem_wr_addr_o(wr_addr), .mem_wr_data_o(wr_data), .write_in_progress_o(write_in_progress),
    .write_enable_latch_o(write_enable_latch), .cont_read_o(cont), .wrap_setting_o(wrap_set));
  sfq_host host (.clk_i(clk_i), .dev_i(lanes_out), .dev_oe_i(lanes_oe), .cs_n_o(cs_n),
    .sclk_o(sclk), .lanes_o(lanes_in));
  // Array content is a fixed function of the address; writes are logged
  function automatic logic [7:0] bytef(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : bytef
  assign rd_data = bytef(rd_addr);
  // Sampled on the falling edge, where the registered write port has settled
  always @(negedge clk_i) begin
    if (wr_en === 1'b1) begin
      wr_mem[wr_addr] = wr_data;
      wr_cnt++;
    end
  end
  // ======================================
  // Checking and closing
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  // Bounded wait for the timed program cycle to end
  task automatic wait_idle();
    int k;
    for (k = 0; k < 2000 && write_in_progress !== 1'b0; k++) @(negedge clk_i);
    if (k == 2000) begin
      failures++;
      finish_test();
    end
  endtask : wait_idle
  // ======================================
  // Frames
  task automatic cmd(input logic [7:0] op);
    host.open_frame();
    host.send8(op);
    host.close_frame();
  endtask : cmd
  task automatic status(output logic [7:0] s);
    host.open_frame();
    host.send8(`SFQ_OP_STATUS);
    host.recv_s(s);
    host.close_frame();
  endtask : status
  task automatic set_wrap(input logic [7:0] w);
    host.open_frame();
    host.send8(`SFQ_OP_SET_WRAP);
    repeat (3) host.send8(8'h00);
    host.send8(w);
    host.close_frame();
    cur_wrap = w;
    chk(wrap_set, w[6:4]);
  endtask : set_wrap
  // Expected address wraps inside the aligned section when wrapping is on
  task automatic quad_read(input sfq_row_s r);
    int len;
    logic [23:0] a;
    len = cur_wrap[4] ? 0 : 8 << cur_wrap[6:5];
    host.open_frame();
    if (!r.skip) host.send8(r.op);
    for (int i = 20; i >= 0; i -= 4) host.cyc(r.addr[i +: 4], 4'hF);
    host.cyc(r.mode[7:4], 4'hF);
    host.cyc(r.mode[3:0], 4'hF);
    repeat (r.op == `SFQ_OP_QWORD ? 2 : 4) host.cyc(4'h0, 4'h0);
    for (int i = 0; i < r.n; i++) begin
      a = (len == 0) ? r.addr + 24'(i)
        : (r.addr & ~24'(len - 1)) | ((r.addr + 24'(i)) & 24'(len - 1));
      host.recv_q(got);
      if (qe) chk(got, bytef(a));
      else chk(lanes_oe, 4'h0);
    end
    host.close_frame();
    chk(cont, qe && r.mode[5:4] == `SFQ_CONT_KEY);
  endtask : quad_read
  // Page program; extra bits leave select rising off a byte boundary
  task automatic prog(input logic [23:0] a, input int n, input int bits);
    wr_cnt = 0;
    wr_mem.delete();
    host.open_frame();
    host.send8(`SFQ_OP_PAGE_WRITE);
    for (int i = 16; i >= 0; i -= 8) host.send8(a[i +: 8]);
    for (int i = 0; i < n; i++) host.send8(8'(i + (i / 256) * 64));
    for (int i = 0; i < bits; i++) host.cyc(4'h1, 4'h1);
    host.close_frame();
  endtask : prog
  // ======================================
  // Main sequence
  initial begin
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({write_in_progress, write_enable_latch, cont, wrap_set, lanes_oe}, {3'h0, 3'h1, 4'h0});
    foreach (rows[i]) begin
      if (!rows[i].skip) set_wrap(rows[i].wrap);
      quad_read(rows[i]);
    end
    @(negedge clk_i);
    qe = 1'b0;
    quad_read('{`SFQ_OP_QREAD, 1'b0, 8'h00, 24'h000800, 8'h00, 2});
    @(negedge clk_i);
    qe = 1'b1;
    prog(24'h001000, 1, 0);
    chk({write_in_progress, write_enable_latch}, 2'h0);
    cmd(`SFQ_OP_UNLOCK);
    chk(write_enable_latch, 1'b1);
    cmd(`SFQ_OP_LOCK);
    chk(write_enable_latch, 1'b0);
    cmd(`SFQ_OP_UNLOCK);
    chk(write_enable_latch, 1'b1);
    prog(24'h001000, 1, 3);
    chk({write_in_progress, write_enable_latch}, 2'h1);
    chk(wr_cnt, 0);
    prog(24'h003000, 1, 0);
    chk({write_in_progress, write_enable_latch}, 2'h1);
    chk(wr_cnt, 0);
    prog(24'h001AFE, 3, 0);
    chk({write_in_progress, write_enable_latch}, 2'h2);
    chk(page, 16'h001A);
    status(got);
    chk(got, 8'h55);
    wait_idle();
    chk({wr_mem[24'h001AFE], wr_mem[24'h001AFF], wr_mem[24'h001A00]}, 24'h000102);
    chk(wr_cnt, 3);
    cmd(`SFQ_OP_UNLOCK);
    prog(24'h002000, 258, 0);
    wait_idle();
    chk({wr_mem[24'h002000], wr_mem[24'h002001], wr_mem[24'h002002]}, 24'h404102);
    chk(wr_cnt, 256);
    // Reset in mid-run while continuous mode and wrapping are active
    set_wrap(8'h00);
    quad_read('{`SFQ_OP_QREAD, 1'b0, 8'h00, 24'h000900, 8'h20, 2});
    @(negedge clk_i);
    nrst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({cont, wrap_set}, 4'h1);
    status(got);
    chk(got, 8'h54);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
